// [logic/pssr_pkg.sv]
// Purpose: shared constants for the pipelined sync sram port
// Assumes: one 50 MHz clock, controller logic on the same clock
// Notes: byte lanes are nine bits wide
package pssr_pkg;
   localparam int ADDR_W = 17;
   localparam int LANES = 4;
   localparam int LANE_W = 9;
   localparam int DATA_W = LANES * LANE_W;
   localparam int WBUF_DEPTH = 16;
   // load to data phase, in clock edges
   localparam int DATA_LAT = 2;
   localparam logic DOE_RST = 1'b0;
   localparam logic VALID_RST = 1'b0;
   localparam logic [DATA_W-1:0] DOUT_RST = 36'h0_0000_0000;
endpackage

// [logic/pssr_sram.sv]
// Purpose: pipelined sync sram core with chip-select handling
// Assumes: controller drives pins from logic on ref_clk
// Notes: burst advance is not modelled; write path runs through a fifo
`timescale 1ns/10ps
`default_nettype none

// ***********************
// write buffer
// ***********************
module pssr_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   // count is one bit wider than the pointers so full and empty differ
   localparam logic [PW:0] FULL = (PW+1)'(DEPTH);
   // pointers wrap freely, so only powers of two are served
   if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
      $error("fifo depth must be a power of two, at least 2");
   end
   if (WIDTH < 1) begin : g_bad_width
      $error("fifo width must be at least 1");
   end
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0] wp_q;
   logic [PW-1:0] rp_q;
   logic [PW:0] cnt_q;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   assign in_ready = (cnt_q != FULL);
   assign out_valid = (cnt_q != '0);
   assign out_data = mem_q[rp_q];
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) wp_q <= wp_q + 1'b1;
         if (pop) rp_q <= rp_q + 1'b1;
         cnt_q <= cnt_q + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
      end
   end
   // ***********************
   // storage
   // ***********************
   always_ff @(posedge ref_clk) begin
      if (push) mem_q[wp_q] <= in_data;
   end
endmodule // pssr_fifo

// ***********************
// sram port
// ***********************
// Functional notes
// - read loaded while selected drives its word two edges after load
// - write loaded while selected stores bus data two edges after load
// - loaded read completes even if deselected the next cycle
// - loaded write captures data even while deselected; controller drives it
// - data outputs float from reset until read data
// - load control low loads address and fixes read or write direction
// - clock hold high makes the device ignore that edge entirely
module pssr_sram #(
   parameter int ADDR_W = pssr_pkg::ADDR_W,
   parameter int LANES = pssr_pkg::LANES,
   parameter int LANE_W = pssr_pkg::LANE_W,
   parameter int WBUF_DEPTH = pssr_pkg::WBUF_DEPTH
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic read_write_n,
   input wire logic advance_or_load_select,
   input wire logic sel_a_n,
   input wire logic sel_b,
   input wire logic sel_c_n,
   input wire logic clock_hold_n,
   input wire logic [LANES-1:0] byte_write_strobes,
   input wire logic [LANES*LANE_W-1:0] data_in,
   output logic [LANES*LANE_W-1:0] data_out,
   output logic data_oe
);
   localparam int DW = LANES * LANE_W;
   localparam int FW = ADDR_W + LANES + DW;
   // ***********************
   // parameter checks
   // ***********************
   // the array is flat, so very wide addresses would not fit a simulator
   if (ADDR_W < 1 || ADDR_W > 24 || LANES < 1 ||
      LANE_W < 1) begin : g_bad_geom
      $error("unsupported sram geometry");
   end
   // the pipeline below is built for exactly two stages
   if (pssr_pkg::DATA_LAT != 2) begin : g_bad_lat
      $error("data latency other than two edges is not built");
   end

   // ***********************
   // select and load decode
   // ***********************
   // hold high blocks the edge from every register
   wire edge_en = !clock_hold_n;
   wire chip_sel = !sel_a_n && sel_b && !sel_c_n;
   // burst advance is out of scope: only a load starts anything
   wire load_op = edge_en && !advance_or_load_select && chip_sel;

   logic s1_v_q;
   logic s1_rd_q;
   logic [ADDR_W-1:0] s1_a_q;
   logic [LANES-1:0] s1_bw_q;
   logic s2_v_q;
   logic s2_rd_q;
   logic [ADDR_W-1:0] s2_a_q;
   logic [LANES-1:0] s2_bw_q;
   logic [DW-1:0] dout_q;
   logic doe_q;
   logic [DW-1:0] mem_q [2**ADDR_W];

   // ***********************
   // write buffer hookup
   // ***********************
   logic wb_in_ready;
   logic wb_out_valid;
   logic [FW-1:0] wb_head;
   // the array write lags the data phase by one edge; the buffer keeps
   // data-phase timing off the array port and forwarding covers the gap
   wire wb_push = edge_en && s2_v_q && !s2_rd_q && wb_in_ready;
   wire [FW-1:0] wb_entry = {s2_a_q, s2_bw_q, data_in};
   // drain also freezes under hold so no state moves on an ignored edge
   wire wb_pop = edge_en && wb_out_valid;
   wire [ADDR_W-1:0] wb_a = wb_head[FW-1 -: ADDR_W];
   wire [LANES-1:0] wb_bw_n = wb_head[DW +: LANES];
   wire [DW-1:0] wb_d = wb_head[DW-1:0];

   pssr_fifo #(.WIDTH(FW), .DEPTH(WBUF_DEPTH)) u_wbuf (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .in_valid(wb_push),
      .in_ready(wb_in_ready),
      .in_data(wb_entry),
      .out_valid(wb_out_valid),
      .out_ready(edge_en),
      .out_data(wb_head)
   );

   // merge active-low byte strobes over an old word
   function automatic logic [DW-1:0] merge(input logic [DW-1:0] old_w,
      input logic [DW-1:0] new_w, input logic [LANES-1:0] bw_n);
      logic [DW-1:0] r;
      r = old_w;
      for (int i = 0; i < LANES; i++) begin
         if (!bw_n[i]) r[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
      end
      return r;
   endfunction

   // the buffer drains each non-held edge, so only its head can match
   // a write still in the buffer must win over the array
   wire [DW-1:0] rd_raw = mem_q[s2_a_q];
   wire fwd_hit = wb_out_valid && (wb_a == s2_a_q);
   wire [DW-1:0] rd_word = fwd_hit ? merge(rd_raw, wb_d, wb_bw_n) : rd_raw;
   wire rd_due = s2_v_q && s2_rd_q;

   // ***********************
   // pipeline
   // ***********************
   // stage one holds the load, stage two is the data phase
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         s1_v_q <= pssr_pkg::VALID_RST;
         s2_v_q <= pssr_pkg::VALID_RST;
      end else if (edge_en) begin
         s1_v_q <= load_op;
         s2_v_q <= s1_v_q;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (load_op) begin
         s1_rd_q <= read_write_n;
         s1_a_q <= addr;
         s1_bw_q <= byte_write_strobes;
      end
      if (edge_en) begin
         s2_rd_q <= s1_rd_q;
         s2_a_q <= s1_a_q;
         s2_bw_q <= s1_bw_q;
      end
   end

   // ***********************
   // array and output
   // ***********************
   always_ff @(posedge ref_clk) begin
      if (wb_pop) mem_q[wb_a] <= merge(mem_q[wb_a], wb_d, wb_bw_n);
   end

   // outputs come from flops so the bus turn-round stays edge aligned
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         doe_q <= pssr_pkg::DOE_RST;
         dout_q <= DW'(pssr_pkg::DOUT_RST);
      end else if (edge_en) begin
         doe_q <= rd_due;
         if (rd_due) dout_q <= rd_word;
      end
   end

   assign data_out = dout_q;
   assign data_oe = doe_q;
endmodule // pssr_sram

`default_nettype wire

// [test/pssr_chk.sv]
// Purpose: port checker for pssr_sram
// Assumes: bound by name to the sram port
// Notes: a held edge delays read data by one edge
`timescale 1ns/10ps
`default_nettype none
module pssr_chk (input wire logic ref_clk, rst_b, read_write_n,
   advance_or_load_select, sel_a_n, sel_b, sel_c_n, clock_hold_n,
   data_oe, input wire logic [35:0] data_out);
   wire h = clock_hold_n;
   wire s = !sel_a_n && sel_b && !sel_c_n;
   wire l = !h && !advance_or_load_select;
   wire r = l && s && read_write_n;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   rd_late_a: assert property (r ##1 !h ##1 !h |=> data_oe)
      else $error("read late");
   rd_desel_a: assert property (r ##1 !s && !h ##1 !h |=> data_oe)
      else $error("read lost");
   wr_float_a: assert property (l && s && !read_write_n
      ##1 !h ##1 !h |=> !data_oe) else $error("write drove bus");
   oe_cause_a: assert property ($rose(data_oe)
      |-> $past(r, 3) || $past(r, 4)) else $error("stray drive");
   part_sel_a: assert property (l && !s ##1 !h ##1 !h |=> !data_oe)
      else $error("deselect ignored");
   adv_high_a: assert property (!h && s && advance_or_load_select
      ##1 !h ##1 !h |=> !data_oe) else $error("no load started op");
   hold_keep_a: assert property (h |=> $stable(data_oe)
      && $stable(data_out)) else $error("held edge acted");
   out_keep_a: assert property (!data_oe |-> $stable(data_out))
      else $error("data changed");
   cover property (r ##1 !s);
   cover property (h);
   cover property (data_oe);
   cover property (l && s && !read_write_n ##1 r);
endmodule // pssr_chk
bind pssr_sram pssr_chk u_chk (
   .ref_clk(ref_clk),
   .rst_b(rst_b),
   .read_write_n(read_write_n),
   .advance_or_load_select(advance_or_load_select),
   .sel_a_n(sel_a_n),
   .sel_b(sel_b),
   .sel_c_n(sel_c_n),
   .clock_hold_n(clock_hold_n),
   .data_oe(data_oe),
   .data_out(data_out)
);
`default_nettype wire

// [test/pssr_ctl_mdl.sv]
// Purpose: controller model facing pssr_sram
// Assumes: calls come from the bench's main flow
// Notes: a released data bus shows the inverse of its last value
`timescale 1ns/10ps
`default_nettype none
module pssr_ctl_mdl (input wire logic ref_clk,
   output logic [16:0] addr, output logic [3:0] byte_write_strobes,
   output logic [35:0] data_in, output logic read_write_n,
   advance_or_load_select, sel_a_n, sel_b, sel_c_n, clock_hold_n);
   logic [35:0] nd = '0, d1, d2;
   logic w1 = 0, w2 = 0;
   wire go = {advance_or_load_select, sel_a_n, sel_b, sel_c_n,
      read_write_n} == 5'b00100;
   task automatic op(input logic [3:0] s, input logic w,
      input logic [16:0] a, input logic [35:0] d, input logic [3:0] b);
      @(posedge ref_clk);
      #1;
      {advance_or_load_select, sel_a_n, sel_b, sel_c_n} = s;
      {read_write_n, addr, nd} = {!w, a, d};
      byte_write_strobes = b;
   endtask
   // deselect, load low, with direction, address, data and strobes turned round
   task automatic idle;
      op(4'b0101, read_write_n, ~addr, ~nd, ~byte_write_strobes);
   endtask
   task automatic hold;
      idle;
      clock_hold_n = 1;
      @(posedge ref_clk);
      #1 clock_hold_n = 0;
   endtask
   initial begin
      {clock_hold_n, data_in, addr, read_write_n} = '0;
      {advance_or_load_select, sel_a_n, sel_b, sel_c_n} = 4'b0101;
      byte_write_strobes = 4'hF;
   end
   always @(posedge ref_clk)
      if (!clock_hold_n) {w1, d1, w2, d2} <= {go, nd, w1, d1};
   always @(posedge ref_clk) #1 data_in = w2 ? d2 : ~data_in;
endmodule // pssr_ctl_mdl
`default_nettype wire

// [test/pssr_sram_tb_top.sv]
// Purpose: self-checking bench for pssr_sram
// Assumes: pssr_ctl_mdl drives every pin but clock and reset
// Notes: words written are read back to see that they landed
`timescale 1ns/10ps
`default_nettype none
`define CK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
   $display("unexpected %0t %h %h", $time, a, b); end end
module pssr_sram_tb_top;
   logic ref_clk = 0, rst_b = 0;
   int n_errors = 0, checked = 0;
   wire [16:0] addr;
   wire [3:0] byte_write_strobes;
   wire [35:0] data_in, data_out;
   wire read_write_n, advance_or_load_select, sel_a_n, sel_b, sel_c_n;
   wire clock_hold_n, data_oe;
   pssr_ctl_mdl c (
      .ref_clk(ref_clk),
      .addr(addr),
      .byte_write_strobes(byte_write_strobes),
      .data_in(data_in),
      .read_write_n(read_write_n),
      .advance_or_load_select(advance_or_load_select),
      .sel_a_n(sel_a_n),
      .sel_b(sel_b),
      .sel_c_n(sel_c_n),
      .clock_hold_n(clock_hold_n)
   );
   pssr_sram DUT (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .addr(addr),
      .read_write_n(read_write_n),
      .advance_or_load_select(advance_or_load_select),
      .sel_a_n(sel_a_n),
      .sel_b(sel_b),
      .sel_c_n(sel_c_n),
      .clock_hold_n(clock_hold_n),
      .byte_write_strobes(byte_write_strobes),
      .data_in(data_in),
      .data_out(data_out),
      .data_oe(data_oe)
   );
   initial forever #10 ref_clk = ~ref_clk;
   // tests need about 100 cycles
   initial begin
      #10000;
      n_errors++;
      summarize;
   end
   task automatic rd(input logic [16:0] a);
      c.op(4'b0010, 1'b0, a, 36'h0, 4'h0);
      c.idle;
      repeat (2) @(posedge ref_clk);
      #1 `CK(data_oe, 1'b1)
   endtask
   task automatic wr(input logic [16:0] a, input logic [35:0] d,
      input logic [3:0] b);
      c.op(4'b0010, 1'b1, a, d, b);
      c.idle;
   endtask
   task automatic t_pipe;
      `CK(data_oe, 1'b0)
      wr(17'h5, 36'hA_5A5A_5A5A, 4'h0);
      wr(17'h6, 36'h3_C3C3_C3C3, 4'h0);
      rd(17'h5);
      `CK(data_out, 36'hA_5A5A_5A5A)
      rd(17'h6);
      `CK(data_out, 36'h3_C3C3_C3C3)
      $display("t_pipe end");
   endtask
   task automatic t_sel;
      for (int i = 0; i < 16; i++) if (i != 2) begin
         c.op(4'(i), 1'b0, 17'h5, 36'h0, 4'h0);
         c.op(4'(i), 1'b1, 17'h5, 36'h0, 4'h0);
         c.idle;
         `CK(data_oe, 1'b0)
      end
      rd(17'h5);
      `CK(data_out, 36'hA_5A5A_5A5A)
      $display("t_sel end");
   endtask
   task automatic t_bw;
      wr(17'h7, 36'h0, 4'h0);
      wr(17'h7, ~36'h0, 4'b1010);
      rd(17'h7);
      `CK(data_out, {9'h0, 9'h1FF, 9'h0, 9'h1FF})
      $display("t_bw end");
   endtask
   task automatic t_hold;
      c.op(4'b0010, 1'b0, 17'h6, 36'h0, 4'h0);
      c.hold;
      @(posedge ref_clk);
      #1 `CK(data_oe, 1'b0)
      @(posedge ref_clk);
      #1 `CK(data_out, 36'h3_C3C3_C3C3)
      $display("t_hold end");
   endtask
   // partial write then read of the same word on the next edge
   task automatic t_fwd;
      c.op(4'b0010, 1'b1, 17'h7, 36'h0, 4'b1110);
      c.op(4'b0010, 1'b0, 17'h7, 36'h0, 4'h0);
      c.idle;
      repeat (2) @(posedge ref_clk);
      #1 `CK(data_oe, 1'b1)
      `CK(data_out, {9'h0, 9'h1FF, 9'h0, 9'h0})
      $display("t_fwd end");
   endtask
   task automatic summarize;
      $display("checked %0d n_errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge ref_clk);
      #1 rst_b = 1;
      t_pipe;
      t_sel;
      t_bw;
      t_hold;
      t_fwd;
      summarize;
   end
endmodule // pssr_sram_tb_top
`default_nettype wire
